// >>> adc_pm_pkg.sv
`default_nettype none
package adc_pm_pkg;
    // =========================================
    // frame and control word layout
    localparam int CTRL_W      = 12;
    localparam int WORD_W      = 16;
    localparam int FRAME_EDGES = 16;
    localparam int TRACK_EDGE  = 14;
    localparam int WRITE_EDGES = 12;
    localparam int WR_POS      = 11;
    localparam int ADDR_HI_POS = 7;
    localparam int ADDR_LO_POS = 6;
    localparam int PM_HI_POS   = 5;
    localparam int PM_LO_POS   = 4;
    localparam logic [1:0]  LEAD_ZEROS = 2'h0;
    localparam logic [11:0] CTRL_RESET = 12'h030;

    // =========================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int WAKE_TIME_NS  = 1000;
    localparam int WAKE_CYCLES   =
        (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W       = $clog2(WAKE_CYCLES + 1);

    // =========================================
    // types
    typedef enum logic [1:0] {
        MODE_UNDEF  = 2'b00,
        MODE_AUTO   = 2'b01,
        MODE_FULL   = 2'b10,
        MODE_NORMAL = 2'b11
    } pm_mode_t;

    typedef enum logic [1:0] {
        PS_OFF  = 2'b00,
        PS_WAKE = 2'b01,
        PS_ON   = 2'b10
    } power_state_t;

    // undefined code behaves as normal mode
    function automatic pm_mode_t decode_mode(input logic [11:0] c);
        pm_mode_t m;
        m = pm_mode_t'({c[PM_HI_POS], c[PM_LO_POS]});
        if (m == MODE_UNDEF) begin
            m = MODE_NORMAL;
        end
        return m;
    endfunction
endpackage
`default_nettype wire

// >>> adc_power_mode_control.sv
// What this block does
// R1 - power mode bits pick normal, full shutdown or auto shutdown
// R2 - chip select fall puts track-and-hold into hold, starts conversion
// R3 - with write bit set, first twelve data bits load control word
// R4 - host writes both mode bits high each write to stay normal
// R5 - write bit low leaves mode bits and mode unchanged
// R6 - sixteen clocks per conversion; track resumes at 14th falling edge
// R7 - host may idle chip select high or low between conversions
// R8 - host spaces conversion starts at least 5 us apart
// R9 - host waits quiet time after chip select rises
// R10 - full shutdown powers all down, keeps control word until changed
// R11 - normal write in full shutdown powers up at closing rise
// R12 - wake write needs full sixteen clocks; output stays undriven
// R13 - host waits power-up time before next conversion start
// R14 - auto shutdown powers down after each update, holding sample
// R15 - auto shutdown wakes on chip select fall, tracking again
// R16 - auto wake-up takes at most 1 us before valid conversion
// R17 - at 20 MHz one dummy transfer wakes from auto shutdown
// R18 - host keeps write bit low during dummy wake transfer
// R19 - after supply-up host sets mode with dummy cycles
// R20 - normal via one dummy cycle, din high, then wait 1 us
// R21 - full shutdown entered at rise of one dummy cycle
// R22 - auto shutdown entered at second dummy cycle's rise
// R23 - early chip select rise aborts, floats output, keeps control
// R24 - output word: two zeros, two address bits, twelve result bits
// R25 - control word written only on full frames with write bit set
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_control
    import adc_pm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic [11:0] sar_code,
    input  wire logic        sar_done,
    output var  logic        dout,
    output var  logic        dout_oe,
    output var  logic        track_mode,
    output var  logic        analog_power_on,
    output var  logic        power_ready,
    output var  logic        conv_start,
    output var  logic [1:0]  mode_code,
    output var  logic [1:0]  channel_sel,
    output var  logic [11:0] control_word
);
    import adc_pm_pkg::*;

    // =========================================
    // state
    typedef struct packed {
        logic                cs_d;
        logic                t14_d;
        logic                t16_d;
        logic                full;
        logic [11:0]         ctrl;
        power_state_t        pstate;
        logic [TIMER_W-1:0]  timer;
        logic                track;
        logic                power_on;
        logic                ready;
        logic                start;
        logic [11:0]         result;
        logic [15:0]         word;
        logic                drive_en;
    } ctl_t;

    ctl_t st_reg;
    ctl_t st_next;

    logic        cs_s;
    logic        cs_act_s;
    logic        t14_s;
    logic        t16_s;
    logic [11:0] frame_word;
    logic        edge14_tog;
    logic        edge16_tog;
    logic        fall;
    logic        rise;
    logic        e14;
    logic        e16;
    logic        done_frame;
    logic        wr;
    pm_mode_t    cur_mode;
    pm_mode_t    new_mode;

    initial begin
        if (WAKE_CYCLES < 2) begin
            $error("wake time shorter than two clock cycles");
        end
    end

    // =========================================
    // link side and crossings
    link_shifter u_link (
        .sclk       (sclk),
        .cs_n       (cs_n),
        .din        (din),
        .srst       (srst),
        .word       (st_reg.word),
        .drive_en   (st_reg.drive_en),
        .dout       (dout),
        .dout_oe    (dout_oe),
        .frame_word (frame_word),
        .edge14_tog (edge14_tog),
        .edge16_tog (edge16_tog)
    );

    sync2 #(.W(3)) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    ({~cs_n, edge14_tog, edge16_tog}),
        .q    ({cs_act_s, t14_s, t16_s})
    );

    // =========================================
    // event decode
    assign cs_s       = ~cs_act_s;
    assign fall       = st_reg.cs_d & ~cs_s;
    assign rise       = ~st_reg.cs_d & cs_s;
    assign e14        = t14_s ^ st_reg.t14_d;
    assign e16        = t16_s ^ st_reg.t16_d;
    assign done_frame = st_reg.full | e16;
    assign wr         = frame_word[WR_POS];
    assign cur_mode   = decode_mode(st_reg.ctrl); // R1
    assign new_mode   = decode_mode(frame_word);

    // =========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.cs_d = cs_s;
        st_next.t14_d = t14_s;
        st_next.t16_d = t16_s;
        st_next.start = 1'b0;
        if (e16) begin
            st_next.full = 1'b1;
        end
        if (sar_done) begin
            st_next.result = sar_code;
        end
        if (e14) begin
            st_next.track = 1'b1; // R6
        end
        unique case (st_reg.pstate)
            PS_WAKE: begin
                if (st_reg.timer <= TIMER_W'(1)) begin
                    st_next.pstate = PS_ON; // R16
                    st_next.ready = 1'b1;
                    st_next.timer = '0;
                end else begin
                    st_next.timer = st_reg.timer - TIMER_W'(1);
                end
            end
            PS_OFF, PS_ON: begin
            end
            default: begin
                st_next.pstate = PS_OFF;
            end
        endcase
        if (fall) begin
            st_next.full = 1'b0;
            st_next.track = 1'b0; // R2
            st_next.start = (st_reg.pstate == PS_ON); // R2
            if (st_reg.pstate == PS_OFF && cur_mode == MODE_AUTO) begin
                st_next.pstate = PS_WAKE; // R15
                st_next.power_on = 1'b1;
                st_next.track = 1'b1; // R15
                st_next.timer = TIMER_W'(WAKE_CYCLES);
            end
        end
        if (rise && done_frame) begin
            if (wr) begin
                st_next.ctrl = frame_word; // R3 R25
            end
            unique case (wr ? new_mode : cur_mode) // R5
                MODE_FULL: begin
                    st_next.pstate = PS_OFF; // R10 R21
                    st_next.power_on = 1'b0;
                    st_next.ready = 1'b0;
                end
                MODE_AUTO: begin
                    st_next.pstate = PS_OFF; // R14 R22
                    st_next.power_on = 1'b0;
                    st_next.ready = 1'b0;
                    st_next.track = 1'b0; // R14
                end
                default: begin
                    if (st_reg.pstate == PS_OFF) begin
                        st_next.pstate = PS_WAKE; // R11 R20
                        st_next.power_on = 1'b1;
                        st_next.timer = TIMER_W'(WAKE_CYCLES);
                    end
                end
            endcase
        end
        if (cs_s && !rise) begin
            st_next.word = {LEAD_ZEROS,
                            st_reg.ctrl[ADDR_HI_POS],
                            st_reg.ctrl[ADDR_LO_POS],
                            st_reg.result}; // R24
            st_next.drive_en = !(st_reg.pstate == PS_OFF
                                 && cur_mode == MODE_FULL); // R12
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '{cs_d: 1'b1, t14_d: 1'b0, t16_d: 1'b0,
                        full: 1'b0, ctrl: CTRL_RESET,
                        pstate: PS_ON, timer: '0, track: 1'b1,
                        power_on: 1'b1, ready: 1'b1, start: 1'b0,
                        result: '0, word: '0, drive_en: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================
    // outputs
    assign track_mode      = st_reg.track;
    assign analog_power_on = st_reg.power_on;
    assign power_ready     = st_reg.ready;
    assign conv_start      = st_reg.start;
    assign mode_code       = {st_reg.ctrl[PM_HI_POS], st_reg.ctrl[PM_LO_POS]};
    assign channel_sel     = {st_reg.ctrl[ADDR_HI_POS],
                              st_reg.ctrl[ADDR_LO_POS]};
    assign control_word    = st_reg.ctrl;

    // =========================================
    // checks
    localparam int wake_lo = WAKE_CYCLES - 1;
    localparam int wake_hi = WAKE_CYCLES;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    hold_on_fall_a: assert property ( // R2
        fall && st_reg.pstate == PS_ON |=> !st_reg.track && st_reg.start)
        else $error("no hold and start on chip select fall");
    track_edge_a: assert property ( // R6
        e14 && !fall |=> st_reg.track)
        else $error("no track after 14th edge");
    nowrite_keep_a: assert property ( // R5
        rise && done_frame && !wr |=> $stable(st_reg.ctrl))
        else $error("control changed without write bit");
    abort_keep_a: assert property ( // R23
        rise && !done_frame |=> $stable(st_reg.ctrl)
                                && $stable(st_reg.pstate))
        else $error("aborted frame changed state");
    write_load_a: assert property ( // R3
        rise && done_frame && wr |=> st_reg.ctrl == $past(frame_word))
        else $error("control word not loaded");
    full_down_a: assert property ( // R10
        cur_mode == MODE_FULL && st_reg.pstate == PS_OFF
        |-> !st_reg.power_on && !st_reg.ready)
        else $error("powered during full shutdown");
    auto_sleep_a: assert property ( // R14
        rise && done_frame && wr && new_mode == MODE_AUTO
        |=> !st_reg.power_on && !st_reg.track ##1 !st_reg.power_on)
        else $error("auto shutdown not entered");
    normal_wake_a: assert property ( // R11
        rise && done_frame && wr && new_mode == MODE_NORMAL
        && st_reg.pstate == PS_OFF |=> st_reg.pstate == PS_WAKE
                                       && st_reg.power_on)
        else $error("no power-up on normal write");
    auto_wake_a: assert property ( // R15
        fall && st_reg.pstate == PS_OFF && cur_mode == MODE_AUTO
        |=> st_reg.track && st_reg.power_on)
        else $error("auto shutdown did not wake");
    wake_time_a: assert property ( // R16
        $rose(st_reg.pstate == PS_WAKE)
        |-> ##[wake_lo:wake_hi] st_reg.ready)
        else $error("wake time wrong");
    no_drive_a: assert property ( // R12
        st_reg.pstate == PS_OFF && cur_mode == MODE_FULL && cs_s && !rise
        |=> !st_reg.drive_en)
        else $error("output enabled in full shutdown");
    start_gate_a: assert property ( // R2
        fall && st_reg.pstate == PS_OFF |=> !st_reg.start)
        else $error("conversion started while powered down");
    full_stay_a: assert property ( // R10
        rise && done_frame && !wr && cur_mode == MODE_FULL
        |=> st_reg.pstate == PS_OFF && !st_reg.power_on)
        else $error("full shutdown left without mode write");
    auto_hold_a: assert property ( // R14
        st_reg.pstate == PS_OFF && cur_mode == MODE_AUTO && !fall
        |=> !st_reg.track)
        else $error("track while in auto shutdown");

    wake_full_c: cover property (
        st_reg.pstate == PS_OFF ##1 st_reg.pstate == PS_WAKE
        ##[wake_lo:wake_hi] st_reg.ready);
    write_auto_c: cover property (
        rise && done_frame && wr && new_mode == MODE_AUTO);
    auto_cycle_c: cover property (
        fall && cur_mode == MODE_AUTO && st_reg.pstate == PS_OFF);
    abort_c: cover property (rise && !done_frame);
    normal_conv_c: cover property (fall && st_reg.pstate == PS_ON);
endmodule
`default_nettype wire

// >>> host_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    // =========================================
    // idle levels, serial clock still outside frames
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // =========================================
    // one transfer: cs fall, edges, cs rise, gap
    task automatic xfer(input  logic [11:0] ctrl,
                        input  int          edges,
                        input  int          gap_ns,
                        output logic [15:0] rd,
                        output int          oe_cnt);
        rd     = 16'h0000;
        oe_cnt = 0;
        cs_n   = 1'b0;
        #62;
        for (int k = 1; k <= edges; k++) begin
            din = (k <= 12) ? ctrl[12-k] : ~din;
            #62;
            rd = {rd[14:0], dout};
            if (dout_oe === 1'b1) begin
                oe_cnt++;
            end
            sclk = 1'b0;
            #63;
            sclk = 1'b1;
        end
        #62;
        cs_n = 1'b1;
        #(gap_ns);
    endtask
endmodule
`default_nettype wire

// >>> link_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module link_shifter
    import adc_pm_pkg::*;
(
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic        srst,
    input  wire logic [15:0] word,
    input  wire logic        drive_en,
    output var  logic        dout,
    output var  logic        dout_oe,
    output var  logic [11:0] frame_word,
    output var  logic        edge14_tog,
    output var  logic        edge16_tog
);
    // =========================================
    // frame state, cleared while chip select is high
    typedef struct packed {
        logic [4:0]  cnt;
        logic [11:0] shift;
        logic        dout;
        logic        oe;
    } frame_t;

    typedef struct packed {
        logic        tog14;
        logic        tog16;
        logic [11:0] hold;
    } event_t;

    frame_t f_reg;
    frame_t f_next;
    event_t e_reg;
    event_t e_next;

    always_comb begin
        f_next = f_reg;
        e_next = e_reg;
        if (f_reg.cnt != 5'(FRAME_EDGES)) begin
            f_next.cnt = f_reg.cnt + 5'h1;
            if (f_reg.cnt < 5'(WRITE_EDGES)) begin
                f_next.shift = {f_reg.shift[10:0], din}; // R3
            end
            if (f_next.cnt == 5'(FRAME_EDGES)) begin
                f_next.oe = 1'b0;
                e_next.tog16 = ~e_reg.tog16;
                e_next.hold = f_reg.shift; // R25
            end else begin
                f_next.dout = word[WORD_W - 1 - int'(f_next.cnt)]; // R24
                f_next.oe = drive_en; // R12
            end
            if (f_next.cnt == 5'(TRACK_EDGE)) begin
                e_next.tog14 = ~e_reg.tog14; // R6
            end
        end
    end

    // =========================================
    // chip select high aborts the frame
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            f_reg <= '0; // R23
        end else begin
            f_reg <= f_next;
        end
    end

    always_ff @(negedge sclk or posedge srst) begin
        if (srst) begin
            e_reg <= '0;
        end else begin
            e_reg <= e_next;
        end
    end

    assign dout       = f_reg.dout;
    assign dout_oe    = f_reg.oe;
    assign frame_word = e_reg.hold;
    assign edge14_tog = e_reg.tog14;
    assign edge16_tog = e_reg.tog16;
endmodule
`default_nettype wire

// >>> sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    // =========================================
    // two-stage level synchroniser
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t sync_reg;
    sync_t sync_next;

    initial begin
        if (W < 1) begin
            $error("sync2 width must be at least one");
        end
    end

    always_comb begin
        sync_next.s1 = d;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg.s2;
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import adc_pm_pkg::*;
    logic        clk;
    logic        srst;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic [11:0] sar_code;
    logic        sar_done;
    logic        dout;
    logic        dout_oe;
    logic        track_mode;
    logic        analog_power_on;
    logic        power_ready;
    logic        conv_start;
    logic [1:0]  mode_code;
    logic [1:0]  channel_sel;
    logic [11:0] control_word;
    int          error_cnt;
    int          samples_checked;
    int          starts;
    int          oe;
    int          s0;
    logic [15:0] rd;
    logic [11:0] c;
    logic [11:0] cw;
    logic [11:0] code;

    adc_power_mode_control i_adc_power_mode_control (
        .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .sar_code(sar_code), .sar_done(sar_done), .dout(dout),
        .dout_oe(dout_oe), .track_mode(track_mode),
        .analog_power_on(analog_power_on), .power_ready(power_ready),
        .conv_start(conv_start), .mode_code(mode_code),
        .channel_sel(channel_sel), .control_word(control_word));
    host_link_model i_host_link_model (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    // =========================================
    // clock, start counter, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) begin
        if (conv_start === 1'b1) starts++;
    end
    initial begin
        #200000;
        error_cnt++;
        $display("ERROR watchdog expected done seen hang");
        summarize();
    end

    // =========================================
    // helpers
    function automatic logic [11:0] mk(input logic wr,
                                       input logic [1:0] pm);
        logic [11:0] v;
        v = 12'($urandom);
        v[WR_POS] = wr;
        v[PM_HI_POS] = pm[1];
        v[PM_LO_POS] = pm[0];
        return v;
    endfunction
    function automatic logic [11:0] exp_ctrl(input logic [11:0] old,
                                             input logic [11:0] nw);
        return nw[WR_POS] ? nw : old;
    endfunction
    task automatic run(input logic [11:0] w, input int n, input int g);
        @(negedge clk);
        i_host_link_model.xfer(w, n, g, rd, oe);
        @(negedge clk);
    endtask
    task automatic chk_ctrl(input logic [11:0] e);
        `CHK("control_word", e, control_word)
        `CHK("mode_code", e[5:4], mode_code)
        `CHK("channel_sel", e[7:6], channel_sel)
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // =========================================
    // tests
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        starts = 0;
        srst = 1'b1;
        sar_code = 12'h000;
        sar_done = 1'b0;
        void'($urandom(32'hAFBF4DE2));
        repeat (16) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk_ctrl(CTRL_RESET);
        `CHK("power_on", 1'b1, analog_power_on)
        `CHK("track", 1'b1, track_mode)
        $display("test reset done");

        run(12'hFFF, 16, 3000);
        chk_ctrl(12'hFFF);
        cw = mk(1'b1, 2'b01);
        run(cw, 16, 3000);
        chk_ctrl(cw);
        `CHK("auto_power", 1'b0, analog_power_on)
        `CHK("auto_hold", 1'b0, track_mode)
        c = mk(1'b0, 2'b11);
        run(c, 16, 3000);
        chk_ctrl(cw);
        `CHK("auto_again", 1'b0, analog_power_on)
        $display("test auto done");

        for (int i = 0; i < 6; i++) begin
            code = 12'($urandom);
            @(negedge clk) begin sar_code = code; sar_done = 1'b1; end
            @(negedge clk) sar_done = 1'b0;
            s0 = starts;
            c = mk(1'b1, 2'b11);
            run(c, 16, 3000);
            cw = exp_ctrl(cw, c);
            chk_ctrl(cw);
            `CHK("result", code, rd[11:0])
            `CHK("zeros", 2'b00, rd[15:14])
            `CHK("oe_count", 15, oe)
            `CHK("starts", s0 + ((i == 0) ? 0 : 1), starts)
            `CHK("track_after", 1'b1, track_mode)
            `CHK("oe_after", 1'b0, dout_oe)
            `CHK("power_on", 1'b1, analog_power_on)
        end
        $display("test normal done");

        c = mk(1'b0, 2'b10);
        run(c, 16, 3000);
        cw = exp_ctrl(cw, c);
        chk_ctrl(cw);
        run(mk(1'b1, 2'b10), 10, 3000);
        chk_ctrl(cw);
        `CHK("abort_oe", 1'b0, dout_oe)
        $display("test keep done");

        cw = mk(1'b1, 2'b10);
        run(cw, 16, 3000);
        chk_ctrl(cw);
        `CHK("full_power", 1'b0, analog_power_on)
        run(mk(1'b0, 2'b11), 16, 3000);
        chk_ctrl(cw);
        `CHK("full_oe", 0, oe)
        cw = mk(1'b1, 2'b11);
        run(cw, 16, 100);
        chk_ctrl(cw);
        `CHK("wake_power", 1'b1, analog_power_on)
        `CHK("wake_early", 1'b0, power_ready)
        `CHK("wake_oe", 0, oe)
        #1100;
        `CHK("wake_ready", 1'b1, power_ready)
        $display("test full done");
        summarize();
    end
endmodule
`default_nettype wire
